// File: logic/itm16_consts.vh
// Constants for the 16-bit interval timer.
// Assumes byte addressing on a 32-bit classic Wishbone bus.
`ifndef ITM16_CONSTS_VH
`define ITM16_CONSTS_VH
// =====================================
// Register byte offsets
`define ITM16_OFS_COUNT   4'h0
`define ITM16_OFS_COMPARE 4'h4
`define ITM16_OFS_CONTROL 4'h8
// =====================================
// Control field positions
`define ITM16_CTL_SEL_LO  0
`define ITM16_CTL_SEL_HI  2
`define ITM16_CTL_RUN     6
`define ITM16_CTL_CLKEN   7
// =====================================
// Reset values
`define ITM16_RST_COUNT   16'h0000
`define ITM16_RST_COMPARE 16'h0000
`define ITM16_RST_CONTROL 8'h00
// =====================================
// Timing
`define ITM16_SYNC_CLKS   4
`define ITM16_PRE_MIN_LOG 2
`endif

// File: logic/itm16_timer.v
// 16-bit interval timer with one double-buffered compare register.
// Assumes a classic Wishbone master on i_clock, 32-bit data.
//
// Functional notes
// [RULE_01] One 16-bit up-counter, one compare, one irq
// [RULE_02] Tick from prescaler, eight ratios fxx/4..fxx/512
// [RULE_03] Software keeps tick rate at 16 MHz max
// [RULE_04] Count register is read-only, writes ignored
// [RULE_05] Counting only while run bit set
// [RULE_06] Counter zero on reset, disables, match, overflow
// [RULE_07] Clock-enable low resets timer immediately
// [RULE_08] Run-bit, match and overflow clears are synchronous
// [RULE_09] Run bit takes effect within four clocks
// [RULE_10] Match raises irq, clears on next tick
// [RULE_11] Compare master written, slave compared, master read
// [RULE_12] Compare value reaches comparator within four clocks
// [RULE_13] Software spaces compare writes four clocks apart
// [RULE_14] Software writes compare once per count cycle
// [RULE_15] Compare below count matches only after wrap
// [RULE_16] Zero compare matches after overflow, once only
// [RULE_17] Software changes prescaler only while stopped
// [RULE_18] Software sets clock-enable alone first
// [RULE_19] Restart: clear run, wait four clocks
// [RULE_20] Compare word access only, control byte access
// [RULE_21] Increment per tick, wrap FFFFH to zero
// [RULE_22] Irq is one system-clock pulse per match
`timescale 1ns/1ps
`include "itm16_consts.vh"

module itm16_timer (
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [3:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  output wire        o_wb_err,
  output reg         o_compare_match_irq
);

  // =====================================
  // Bus decode
  reg         err_r;
  wire        req_w     = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~err_r;
  wire        hit_count = (i_wb_adr == `ITM16_OFS_COUNT);
  wire        hit_comp  = (i_wb_adr == `ITM16_OFS_COMPARE);
  wire        hit_ctl   = (i_wb_adr == `ITM16_OFS_CONTROL);
  // Compare needs both low lanes, control uses lane 0 only
  wire        comp_ok   = (i_wb_sel[1:0] == 2'h3); // RULE_20
  wire        bad_w     = ~(hit_count | hit_comp | hit_ctl) |
                          (hit_comp & ~comp_ok);
  wire        wr_comp   = req_w & i_wb_we & hit_comp & comp_ok; // RULE_20
  wire        wr_ctl    = req_w & i_wb_we & hit_ctl & i_wb_sel[0]; // RULE_20

  // =====================================
  // Control register
  reg  [7:0]  control_r;
  reg  [7:0]  control_nxt;
  wire        clken_w   = control_r[`ITM16_CTL_CLKEN];
  wire        run_w     = control_r[`ITM16_CTL_RUN];
  wire [2:0]  sel_w     = control_r[`ITM16_CTL_SEL_HI:`ITM16_CTL_SEL_LO];

  always @*
  begin
    control_nxt = control_r;
    if (wr_ctl)
    begin
      control_nxt = i_wb_dat[7:0];
    end
  end

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      control_r <= `ITM16_RST_CONTROL;
    end
    else
    begin
      control_r <= control_nxt;
    end
  end

  // Clock-enable low clears the timer core at once, with no edge;
  // it comes straight from a flop, so it cannot glitch. System
  // reset clears the control register and so reaches the core too.
  wire        core_clr_w = ~clken_w; // RULE_07

  // =====================================
  // Run bit and compare transfer pipelines
  reg  [`ITM16_SYNC_CLKS-2:0] run_pipe_r;
  wire        run_int_w = run_pipe_r[`ITM16_SYNC_CLKS-2];
  reg  [15:0] comp_master_r;
  reg  [15:0] comp_slave_r;
  reg  [`ITM16_SYNC_CLKS-2:0] comp_pend_r;

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      run_pipe_r <= {(`ITM16_SYNC_CLKS-1){1'b0}};
    end
    else
    begin
      // Three stages plus control flop gives four clocks
      run_pipe_r <= {run_pipe_r[`ITM16_SYNC_CLKS-3:0], run_w}; // RULE_09
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      comp_pend_r <= {(`ITM16_SYNC_CLKS-1){1'b0}};
    end
    else
    begin
      comp_pend_r <= {comp_pend_r[`ITM16_SYNC_CLKS-3:0], wr_comp};
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      comp_master_r <= `ITM16_RST_COMPARE;
    end
    else if (wr_comp)
    begin
      comp_master_r <= i_wb_dat[15:0]; // RULE_11
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      comp_slave_r <= `ITM16_RST_COMPARE;
    end
    else if (comp_pend_r[`ITM16_SYNC_CLKS-2])
    begin
      comp_slave_r <= comp_master_r; // RULE_11 RULE_12
    end
  end

  // =====================================
  // Prescaler
  reg  [8:0]  pre_r;
  reg         tick_r;
  wire [8:0]  pre_mask_w = (9'h001 << (sel_w + `ITM16_PRE_MIN_LOG)) -
                           9'h001; // RULE_02

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      pre_r <= 9'h000;
    end
    else if (~run_int_w)
    begin
      // Held at zero while stopped so a restart is a clean period
      pre_r <= 9'h000;
    end
    else
    begin
      pre_r <= (pre_r + 9'h001) & pre_mask_w;
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      tick_r <= 1'b0;
    end
    else if (~run_int_w)
    begin
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= ((pre_r & pre_mask_w) == pre_mask_w); // RULE_02
    end
  end

  // =====================================
  // Counter and compare
  reg  [15:0] count_r;
  reg  [15:0] count_nxt;
  reg         clr_pend_r;
  reg         clr_pend_nxt;
  reg         match_nxt;
  // Start value is not judged; only a value reached by counting
  reg         counted_r;
  reg         counted_nxt;

  always @*
  begin
    count_nxt    = count_r;
    clr_pend_nxt = clr_pend_r;
    counted_nxt  = counted_r;
    match_nxt    = 1'b0;
    if (tick_r)
    begin
      if (clr_pend_r)
      begin
        // Clear after match; a zero reached this way is not judged
        count_nxt    = 16'h0000; // RULE_10 RULE_08 RULE_16
        clr_pend_nxt = 1'b0;
        counted_nxt  = 1'b0;
      end
      else
      begin
        // Wrap on overflow; low compare waits for the wrap
        count_nxt   = count_r + 16'h0001; // RULE_21 RULE_15 RULE_06
        counted_nxt = 1'b1;
      end
    end
    if (counted_r & ~clr_pend_r & (count_r == comp_slave_r) &
        ~(tick_r & clr_pend_r))
    begin
      // Compare is judged on every clock while no clear is pending
      if (~clr_pend_r)
      begin
        match_nxt    = 1'b1; // RULE_10 RULE_16
        clr_pend_nxt = 1'b1;
      end
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      count_r <= `ITM16_RST_COUNT; // RULE_06
    end
    else if (~run_int_w)
    begin
      // Stop clears synchronously
      count_r <= `ITM16_RST_COUNT; // RULE_05 RULE_08
    end
    else
    begin
      count_r <= count_nxt; // RULE_01
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      clr_pend_r <= 1'b0;
    end
    else if (~run_int_w)
    begin
      clr_pend_r <= 1'b0;
    end
    else
    begin
      clr_pend_r <= clr_pend_nxt;
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      counted_r <= 1'b0;
    end
    else if (~run_int_w)
    begin
      counted_r <= 1'b0;
    end
    else
    begin
      counted_r <= counted_nxt;
    end
  end

  always @(posedge i_clock or posedge core_clr_w)
  begin
    if (core_clr_w)
    begin
      o_compare_match_irq <= 1'b0;
    end
    else if (~run_int_w)
    begin
      o_compare_match_irq <= 1'b0;
    end
    else
    begin
      o_compare_match_irq <= match_nxt; // RULE_22
    end
  end

  // =====================================
  // Bus answer, one wait state
  reg  [31:0] rd_nxt;

  always @*
  begin
    rd_nxt = 32'h00000000;
    if (hit_count)
    begin
      rd_nxt = {16'h0000, count_r}; // RULE_04
    end
    else if (hit_comp)
    begin
      rd_nxt = {16'h0000, comp_master_r}; // RULE_11
    end
    else if (hit_ctl)
    begin
      rd_nxt = {24'h000000, control_r};
    end
  end

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
    end
    else
    begin
      // A held request is not answered on two clocks in a row
      o_wb_ack <= req_w & ~bad_w;
    end
  end

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      err_r <= 1'b0;
    end
    else
    begin
      err_r <= req_w & bad_w;
    end
  end

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_wb_dat <= 32'h00000000;
    end
    else if (req_w & ~i_wb_we)
    begin
      // Read data holds until the next read
      o_wb_dat <= rd_nxt;
    end
  end

  assign o_wb_err = err_r;

endmodule // itm16_timer

// File: verif/itm16_timer_chk.sv
// Checker for the interval timer's bus and irq ports.
// Assumes it is bound to itm16_timer; one clock, sync reset.
`timescale 1ns/1ps
module itm16_timer_chk (
  input wire        i_clock,
  input wire        i_rst,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [3:0]  i_wb_adr,
  input wire [3:0]  i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack,
  input wire        o_wb_err,
  input wire        o_compare_match_irq
);
  // ==========
  // Helpers
  reg  run_r;
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
  // Run seen at the ack edge, one clock after the write lands
  always @(posedge i_clock)
    if (i_rst)
      run_r <= 1'h0;
    else if (o_wb_ack && i_wb_we && i_wb_adr == 4'h8 && i_wb_sel[0])
      run_r <= i_wb_dat[6] & i_wb_dat[7];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========
  // Properties
  irq_pulse_a: assert property (
    o_compare_match_irq |=> !o_compare_match_irq) else $error("irq long");
  irq_gap_a: assert property (
    o_compare_match_irq |=> !o_compare_match_irq [*3]) else $error("gap");
  rst_quiet_a: assert property (
    $fell(i_rst) |-> !o_compare_match_irq [*6]) else $error("irq at reset");
  // Run pipe lags the write, so allow a short tail
  irq_run_a: assert property (
    o_compare_match_irq |-> run_r || $past(run_r, 6)) else $error("stopped");
  cmp_err_a: assert property (
    req && i_wb_adr == 4'h4 && i_wb_sel[1:0] != 2'h3 |=> o_wb_err && !o_wb_ack)
    else $error("compare part access");
  cmp_ok_a: assert property (
    req && i_wb_adr == 4'h4 && i_wb_sel[1:0] == 2'h3 |=> o_wb_ack && !o_wb_err)
    else $error("compare word access");
  cnt_ro_a: assert property (
    req && i_wb_we && i_wb_adr == 4'h0 |=> o_wb_ack && !o_wb_err)
    else $error("count write");
  unmap_err_a: assert property (
    req && i_wb_adr[3:2] == 2'h3 |=> o_wb_err && !o_wb_ack) else $error("map");
  cover property (o_compare_match_irq);
  cover property (o_wb_err);
  cover property (o_wb_ack && !i_wb_we);
endmodule // itm16_timer_chk
bind itm16_timer itm16_timer_chk i_itm16_timer_chk (.i_clock, .i_rst,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .o_wb_err, .o_compare_match_irq);

// File: verif/itm16_timer_bench.sv
// Self-checking bench for the interval timer.
// Assumes the bound checker; 10 MHz clock, Wishbone master here.
`timescale 1ns/1ps
module itm16_timer_bench;
  // ==========
  // Signals and design
  logic        i_clock = 1'h0;
  logic        i_rst = 1'h1;
  logic        i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic [3:0]  i_wb_adr = 4'h0, i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
  logic        o_wb_ack, o_wb_err, o_compare_match_irq, er;
  integer      miscompares = 0, compares = 0, cyc = 0, n, s;
  always #50 i_clock = ~i_clock;
  itm16_timer i_itm16_timer (.i_clock, .i_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .o_wb_err, .o_compare_match_irq);
  // ==========
  // Tasks
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      test_done;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [3:0] m,
          input logic [31:0] d);
    integer k;
    @(posedge i_clock);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_sel <= m;
    i_wb_dat <= d;
    k = 0;
    @(posedge i_clock);
    while (o_wb_ack !== 1'h1 && o_wb_err !== 1'h1 && k < 50)
    begin
      @(posedge i_clock);
      k++;
    end
    rd = o_wb_dat;
    er = o_wb_err;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    chk(k < 50, 32'h1);
  endtask
  // Counts edges up to the next irq; 5000 means none came
  task wirq;
    n = 1;
    @(posedge i_clock);
    while (o_compare_match_irq !== 1'h1 && n < 5000)
    begin
      @(posedge i_clock);
      n++;
    end
  endtask
  // ==========
  // Scenarios
  task t_regs;
    wb(1'h1, 4'h8, 4'h1, 32'h80);
    wb(1'h1, 4'h0, 4'hF, 32'h1234);
    wb(1'h0, 4'h0, 4'hF, 32'h0);
    chk(rd, 32'h0);
    wb(1'h1, 4'h4, 4'h3, 32'hABC);
    repeat (4) @(posedge i_clock);
    wb(1'h1, 4'h4, 4'hC, 32'h555);
    chk(er, 32'h1);
    wb(1'h0, 4'h4, 4'h3, 32'h0);
    chk(rd, 32'hABC);
    wb(1'h0, 4'hC, 4'hF, 32'h0);
    chk(er, 32'h1);
  endtask
  task t_rates;
    wb(1'h1, 4'h4, 4'h3, 32'h3);
    for (s = 0; s < 8; s++)
    begin
      wb(1'h1, 4'h8, 4'h1, 32'h80);
      repeat (4) @(posedge i_clock);
      wb(1'h1, 4'h8, 4'h1, 32'hC0 | s);
      wirq;
      wirq;
      chk(n, 32'h10 << s);
    end
  endtask
  task t_late;
    wb(1'h1, 4'h8, 4'h1, 32'h80);
    repeat (4) @(posedge i_clock);
    wb(1'h1, 4'h4, 4'h3, 32'h40);
    wb(1'h1, 4'h8, 4'h1, 32'hC0);
    repeat (100) @(posedge i_clock);
    wb(1'h1, 4'h4, 4'h3, 32'h8);
    wirq;
    chk(n, 32'h1388);
  endtask
  task t_stop;
    wb(1'h1, 4'h8, 4'h1, 32'h80);
    repeat (50) @(posedge i_clock);
    wb(1'h0, 4'h0, 4'hF, 32'h0);
    chk(rd, 32'h0);
    wb(1'h1, 4'h8, 4'h1, 32'h0);
    wb(1'h0, 4'h4, 4'h3, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'h0;
    t_regs;
    t_rates;
    t_late;
    t_stop;
    test_done;
  end
endmodule // itm16_timer_bench
